/* File: logic/eep_pkg.sv */
// constants and types shared by the two-wire eeprom target
package eep_pkg;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGES      = 512;
  localparam int unsigned MAIN_BYTES = PAGE_BYTES * PAGES;
  localparam int unsigned ID_BYTES   = 64;
  localparam int unsigned ARR_AW     = 16;
  localparam int unsigned ARR_DEPTH  = MAIN_BYTES + ID_BYTES;
  localparam int unsigned BUF_AW     = 6;
  localparam logic [15:0] ID_BASE    = 16'h8000;
  localparam logic [3:0]  TYPE_MAIN  = 4'hA;
  localparam logic [3:0]  TYPE_ID    = 4'hB;
  localparam int unsigned LOCK_BIT   = 10;
  localparam int unsigned UID_BIT    = 11;
  // arbitrary value, no meaning
  localparam logic [127:0] UID_DEFAULT =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [3:0]  ACK_SLOT   = 4'h8;
  localparam logic [3:0]  ACK_END    = 4'h9;
  localparam logic [6:0]  COPY_LAST  = 7'h40;
  localparam int unsigned T_WR_US    = 3000;
  localparam int unsigned CLK_MHZ    = 50;
  localparam int unsigned WR_CYC     = T_WR_US * CLK_MHZ;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] strap;
  } eep_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADDR_H, ST_ADDR_L, ST_WDATA, ST_RDATA
  } eep_state_t;
endpackage : eep_pkg

/* File: logic/eep_mem.sv */
// single-port byte memory with registered read data
`timescale 1ns/1ns
module eep_mem #(
  parameter int unsigned AW    = 6,
  parameter int unsigned DEPTH = 64
) (
  input  wire logic          clk_i,   // clock
  input  wire logic          we_i,    // write strobe
  input  wire logic [AW-1:0] addr_i,  // byte address
  input  wire logic [7:0]    wdata_i, // write data
  output logic      [7:0]    rdata_o  // read data, registered
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
    $error("eep_mem: depth does not fit address width");
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : eep_mem

/* File: logic/eep_target.sv */
// two-wire serial eeprom target: protocol, array, id page, write timer
// Operation
// - sample data on rising clock edges, change output on falling edges
// - data line is open drain: pull low or release, also input
// - three strap inputs form part of the bus address, eight devices
// - floating strap inputs count as zero; there is no pull here, straps are sampled as driven
// - protect input high: no array location is ever modified
// - protect high: ack address and word bytes, nack data bytes
// - protect low or floating permits writes; there is no pull here, wp is sampled as driven
// - main array is 512 pages of 64 bytes, 32768 bytes
// - byte, full page or partial page writes accepted
// - programming self-timed, done within 3 ms
// - 64-byte id page, writable until permanently locked; the lock flag here is cleared by reset
// - 128-bit read-only unique id, returned on dedicated read
// - type 1010 selects main array, 1011 id page or unique id
// - ack address byte only on strap match; last bit one reads
// - two word address bytes follow, high first, each acked
// - programming starts only at a stop ending a write
`timescale 1ns/1ns
module eep_target #(
  parameter int unsigned    WR_CYCLES = eep_pkg::WR_CYC,
  parameter logic [127:0]   UID       = eep_pkg::UID_DEFAULT
) (
  input  wire logic ref_clk_i,          // system clock
  input  wire logic rstn_i,             // async reset, active low
  input  wire logic scl_i,              // bus clock pin
  input  wire logic sda_i,              // data pin level
  output logic      sda_o,              // data pin drive value
  output logic      sda_oe_o,           // data pin pulled low when high
  input  wire logic wp_i,               // write protect pin
  input  wire logic strap_addr_bit0_i,  // address strap 0
  input  wire logic strap_addr_bit1_i,  // address strap 1
  input  wire logic strap_addr_bit2_i,  // address strap 2
  output logic      busy_o              // internal write cycle running
);
  localparam int unsigned TW = $clog2(WR_CYCLES + 1);
  if (WR_CYCLES <= 65) begin : g_chk
    $error("eep_target: write time shorter than page copy");
  end

  logic              rst_meta;
  logic              rst_n;
  eep_pkg::eep_pins_t pins_in;
  eep_pkg::eep_pins_t pins_meta;
  eep_pkg::eep_pins_t pins_s;
  logic              scl_q;
  logic              sda_q;

  eep_pkg::eep_state_t state_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        rx_reg;
  logic [7:0]        tx_reg;
  logic [15:0]       ptr_reg;
  logic              oe_reg;
  logic              acked_reg;
  logic              mack_reg;
  logic              is_id_reg;
  logic              pend_reg;
  logic              lock_pend_reg;
  logic              locked_reg;
  logic [63:0]       valid_reg;
  logic              wr_id_reg;
  logic [8:0]        wr_page_reg;
  logic              busy_reg;
  logic [TW-1:0]     timer_reg;
  logic [6:0]        cp_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pins pass two flops before use; straps and wp reset to zero, there are no pulls
  assign pins_in = '{scl: scl_i, sda: sda_i, wp: wp_i,
                     strap: {strap_addr_bit2_i, strap_addr_bit1_i,
                             strap_addr_bit0_i}};
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      pins_s    <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      pins_meta <= pins_in;
      pins_s    <= pins_meta;
      scl_q     <= pins_s.scl;
      sda_q     <= pins_s.sda;
    end
  end

  wire scl_rise  = pins_s.scl & ~scl_q;
  wire scl_fall  = ~pins_s.scl & scl_q;
  wire start_det = pins_s.scl & scl_q & sda_q & ~pins_s.sda;
  wire stop_det  = pins_s.scl & scl_q & ~sda_q & pins_s.sda;
  wire active    = (state_reg != eep_pkg::ST_IDLE);
  // decode of the addressing byte
  wire type_ok   = (rx_reg[7:4] == eep_pkg::TYPE_MAIN)
                 | (rx_reg[7:4] == eep_pkg::TYPE_ID);
  wire strap_ok  = (rx_reg[3:1] == pins_s.strap);
  wire dev_ack   = type_ok & strap_ok & ~busy_reg;
  wire lock_cmd  = is_id_reg & ptr_reg[eep_pkg::LOCK_BIT];
  wire uid_sel   = is_id_reg & ptr_reg[eep_pkg::UID_BIT];
  wire wr_ok     = ~pins_s.wp & ~(is_id_reg & locked_reg)
                 & ~(lock_cmd & ~ptr_reg[eep_pkg::UID_BIT]
                     & locked_reg)
                 & ~(is_id_reg & ptr_reg[eep_pkg::UID_BIT]);
  wire ack_now   = (state_reg == eep_pkg::ST_DEV)    ? dev_ack :
                   (state_reg == eep_pkg::ST_ADDR_H) ? 1'b1 :
                   (state_reg == eep_pkg::ST_ADDR_L) ? 1'b1 :
                   (state_reg == eep_pkg::ST_WDATA)  ? wr_ok :
                   1'b0;

  // read pointer advance; id page wraps within its 64 bytes
  wire [15:0] ptr_inc = is_id_reg
                      ? {ptr_reg[15:6], ptr_reg[5:0] + 6'h01}
                      : {ptr_reg[15], ptr_reg[14:0] + 15'h0001};
  wire [5:0]  wr_low  = ptr_reg[5:0] + 6'h01;
  wire [7:0] arr_rdata;
  wire [7:0] buf_rdata;
  wire [7:0] uid_byte = UID[{~ptr_reg[3:0], 3'h0} +: 8];
  wire [7:0] rd_byte  = uid_sel ? uid_byte : arr_rdata;
  wire end_slot = scl_fall & (cnt_reg == eep_pkg::ACK_END);
  wire buf_we   = active & end_slot & acked_reg & ~lock_cmd
                & (state_reg == eep_pkg::ST_WDATA);
  wire prog_go  = stop_det & (pend_reg | lock_pend_reg);

  // bit engine and command sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= eep_pkg::ST_IDLE;
      cnt_reg       <= 4'h0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'hFF;
      ptr_reg       <= 16'h0000;
      oe_reg        <= 1'b0;
      acked_reg     <= 1'b0;
      mack_reg      <= 1'b1;
      is_id_reg     <= 1'b0;
      pend_reg      <= 1'b0;
      lock_pend_reg <= 1'b0;
      valid_reg     <= 64'h0;
      wr_id_reg     <= 1'b0;
      wr_page_reg   <= 9'h000;
    end else if (start_det) begin
      state_reg     <= eep_pkg::ST_DEV;
      cnt_reg       <= 4'h0;
      oe_reg        <= 1'b0;
      pend_reg      <= 1'b0;
      lock_pend_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg     <= eep_pkg::ST_IDLE;
      oe_reg        <= 1'b0;
      pend_reg      <= 1'b0;
      lock_pend_reg <= 1'b0;
    end else if (active && scl_rise) begin
      if (cnt_reg < eep_pkg::ACK_SLOT) begin
        rx_reg <= {rx_reg[6:0], pins_s.sda};
      end else begin
        mack_reg <= pins_s.sda;
      end
      cnt_reg <= cnt_reg + 4'h1;
    end else if (active && scl_fall) begin
      if (cnt_reg == eep_pkg::ACK_SLOT) begin
        if (state_reg == eep_pkg::ST_RDATA) begin
          oe_reg  <= 1'b0;
          ptr_reg <= ptr_inc;
        end else begin
          oe_reg    <= ack_now;
          acked_reg <= ack_now;
          if (state_reg == eep_pkg::ST_DEV) begin
            is_id_reg <= (rx_reg[7:4] == eep_pkg::TYPE_ID);
          end
        end
      end else if (cnt_reg == eep_pkg::ACK_END) begin
        cnt_reg <= 4'h0;
        oe_reg  <= 1'b0;
        case (state_reg)
          eep_pkg::ST_DEV: begin
            if (!acked_reg) begin
              state_reg <= eep_pkg::ST_IDLE;
            end else if (rx_reg[0]) begin
              state_reg <= eep_pkg::ST_RDATA;
              tx_reg    <= rd_byte;
              oe_reg    <= ~rd_byte[7];
            end else begin
              state_reg <= eep_pkg::ST_ADDR_H;
            end
          end
          eep_pkg::ST_ADDR_H: begin
            ptr_reg[15:8] <= rx_reg;
            state_reg     <= eep_pkg::ST_ADDR_L;
          end
          eep_pkg::ST_ADDR_L: begin
            ptr_reg[7:0] <= rx_reg;
            state_reg    <= eep_pkg::ST_WDATA;
            valid_reg    <= 64'h0;
            wr_id_reg    <= is_id_reg;
            wr_page_reg  <= {ptr_reg[14:8], rx_reg[7:6]};
          end
          eep_pkg::ST_WDATA: begin
            if (!acked_reg) begin
              state_reg <= eep_pkg::ST_IDLE;
            end else if (lock_cmd) begin
              lock_pend_reg <= 1'b1;
            end else begin
              pend_reg                <= 1'b1;
              valid_reg[ptr_reg[5:0]] <= 1'b1;
              ptr_reg[5:0]            <= wr_low;
            end
          end
          eep_pkg::ST_RDATA: begin
            if (mack_reg) begin
              state_reg <= eep_pkg::ST_IDLE;
            end else begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
            end
          end
          default: state_reg <= eep_pkg::ST_IDLE;
        endcase
      end else if (state_reg == eep_pkg::ST_RDATA) begin
        oe_reg <= ~tx_reg[~cnt_reg[2:0]];
      end
    end
  end

  // self-timed write cycle: page buffer copied, then timer runs out
  wire timer_done = (timer_reg == TW'(WR_CYCLES - 1));
  wire [6:0] cp_m1 = cp_reg - 7'h01;
  wire copy_we = busy_reg & (cp_reg != 7'h00)
               & (cp_reg <= eep_pkg::COPY_LAST)
               & valid_reg[cp_m1[5:0]];
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg   <= 1'b0;
      timer_reg  <= '0;
      cp_reg     <= 7'h00;
      locked_reg <= 1'b0;
    end else if (prog_go && !busy_reg) begin
      // lock programs through the same timed cycle
      busy_reg  <= 1'b1;
      timer_reg <= '0;
      cp_reg    <= 7'h00;
      if (lock_pend_reg) begin
        locked_reg <= 1'b1;
      end
    end else if (busy_reg) begin
      timer_reg <= timer_reg + TW'(1);
      if (cp_reg <= eep_pkg::COPY_LAST) begin
        cp_reg <= cp_reg + 7'h01;
      end
      if (timer_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  wire [15:0] rd_addr   = is_id_reg
                        ? (eep_pkg::ID_BASE | {10'h000, ptr_reg[5:0]})
                        : {1'b0, ptr_reg[14:0]};
  wire [15:0] copy_addr = wr_id_reg
                        ? (eep_pkg::ID_BASE | {10'h000, cp_m1[5:0]})
                        : {1'b0, wr_page_reg, cp_m1[5:0]};
  wire [15:0] arr_addr  = busy_reg ? copy_addr : rd_addr;
  wire [5:0]  buf_addr  = busy_reg ? cp_reg[5:0] : ptr_reg[5:0];

  eep_mem #(
    .AW    (eep_pkg::ARR_AW),
    .DEPTH (eep_pkg::ARR_DEPTH)
  ) u_array (
    .clk_i   (ref_clk_i),
    .we_i    (copy_we),
    .addr_i  (arr_addr),
    .wdata_i (buf_rdata),
    .rdata_o (arr_rdata)
  );

  eep_mem #(
    .AW    (eep_pkg::BUF_AW),
    .DEPTH (eep_pkg::PAGE_BYTES)
  ) u_page_buf (
    .clk_i   (ref_clk_i),
    .we_i    (buf_we),
    .addr_i  (buf_addr),
    .wdata_i (rx_reg),
    .rdata_o (buf_rdata)
  );
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_reg;
  assign busy_o   = busy_reg;
endmodule : eep_target

/* File: test/eep_target_asserts.sv */
// port checks for the two-wire eeprom target
`timescale 1ns/1ns
module eep_target_asserts #(
  parameter int unsigned WR_CYCLES = 200
) (
  input wire logic ref_clk_i,         // clock
  input wire logic rstn_i,            // reset, low
  input wire logic scl_i,             // bus clock
  input wire logic sda_i,             // data line
  input wire logic sda_o,             // drive value
  input wire logic sda_oe_o,          // pulls low
  input wire logic wp_i,              // protect
  input wire logic strap_addr_bit0_i, // strap 0
  input wire logic strap_addr_bit1_i, // strap 1
  input wire logic strap_addr_bit2_i, // strap 2
  input wire logic busy_o             // programming
);
  logic [31:0] cnt_reg;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_reg <= '0;
    else cnt_reg <= busy_o ? cnt_reg + 32'h1 : '0;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_drive_zero: assert property (sda_o == 1'h0)
    else $error("data drive value not zero");
  a_oe_moves_low: assert property (
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("data drive changed near clock high");
  a_oe_holds_high: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive moved while clock high");
  a_busy_length: assert property (
    $fell(busy_o) |-> cnt_reg == WR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_bound: assert property (busy_o |-> cnt_reg < WR_CYCLES)
    else $error("write cycle too long");
  a_busy_at_stop: assert property (
    $rose(busy_o) |-> scl_i && sda_i && !$past(sda_i, 6))
    else $error("write cycle began without stop");
  a_quiet_busy: assert property (busy_o |-> !sda_oe_o)
    else $error("drove data line while programming");
  a_protect_no_prog: assert property (
    $rose(busy_o) |-> !(wp_i && $past(wp_i, 30)))
    else $error("programming under write protect");
endmodule : eep_target_asserts

bind eep_target eep_target_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
  .strap_addr_bit0_i(strap_addr_bit0_i),
  .strap_addr_bit1_i(strap_addr_bit1_i),
  .strap_addr_bit2_i(strap_addr_bit2_i), .busy_o(busy_o));

/* File: test/eep_bus_master.sv */
// two-wire bus master model, pins moved at falling ref edges
`timescale 1ns/1ns
module eep_bus_master (
  input  wire logic       clk_i,     // reference clock
  input  wire logic       sda_i,     // resolved data line
  output logic            scl_o,     // bus clock, idle high
  output logic            sda_low_o, // high pulls data low
  output logic            res_v_o,   // strobe per byte
  output logic      [8:0] res_d_o    // byte and ninth bit
);
  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
    res_v_o = 1'h0;
    res_d_o = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  // low phase 5, high phase 3; a one is a release
  // fixed 8-cycle bus period, the bench's scaled bus rate
  task automatic bit_x(input logic b, output logic s);
    tick(1);
    sda_low_o <= !b;
    tick(4);
    scl_o <= 1'h1;
    tick(1);
    s = sda_i;
    tick(2);
    scl_o <= 1'h0;
  endtask : bit_x
  // also serves as repeated start
  task automatic start();
    tick(1);
    sda_low_o <= 1'h0;
    tick(4);
    scl_o <= 1'h1;
    tick(2);
    sda_low_o <= 1'h1;
    tick(2);
    scl_o <= 1'h0;
  endtask : start
  task automatic stop();
    tick(1);
    sda_low_o <= 1'h1;
    tick(4);
    scl_o <= 1'h1;
    tick(2);
    sda_low_o <= 1'h0;
    tick(4);
  endtask : stop
  task automatic xfer(input logic [8:0] v);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) bit_x(v[i], r[i]);
    res_d_o <= r;
    res_v_o <= 1'h1;
    tick(1);
    res_v_o <= 1'h0;
  endtask : xfer
endmodule : eep_bus_master

/* File: test/eep_target_tb_top.sv */
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ns
module eep_target_tb_top;
  localparam int unsigned  WR = 200;
  localparam logic [127:0] UIDV =
    128'h5051_5253_5455_5657_5859_5A5B_5C5D_5E5F;
  logic               clk;
  logic               rstn;
  eep_pkg::eep_pins_t pins;
  logic               scl;
  logic               sda;
  logic               oe;
  logic               m_low;
  logic               busy;
  logic               res_v;
  logic [8:0]         res_d;
  logic [8:0]         exp_q[$];
  int                 fails;
  int                 checked;
  logic [7:0]         d;
  logic [14:0]        a;
  assign sda = !(oe || m_low);
  always #10 clk = ~clk;
  eep_target #(.WR_CYCLES(WR), .UID(UIDV)) uut (
    .ref_clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(oe), .wp_i(pins.wp), .strap_addr_bit0_i(pins.strap[0]),
    .strap_addr_bit1_i(pins.strap[1]), .strap_addr_bit2_i(pins.strap[2]),
    .busy_o(busy));
  eep_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(m_low), .res_v_o(res_v), .res_d_o(res_d));
  task automatic check(input string nm, input logic [8:0] seen,
                       input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tx(input logic [7:0] b, input logic nack);
    exp_q.push_back({b, nack});
    m.xfer({b, 1'h1});
  endtask : tx
  task automatic rx(input logic [7:0] b, input logic last);
    exp_q.push_back({b, last});
    m.xfer({8'hFF, last});
  endtask : rx
  task automatic wait_idle();
    for (int i = 0; busy !== 1'h0; i++) begin
      if (i > 2 * WR) begin
        check("busy wait", {8'h00, busy}, 9'h000);
        tally_and_finish();
      end
      @(negedge clk);
    end
  endtask : wait_idle
  task automatic adr(input logic [3:0] t, input logic [15:0] w);
    m.start();
    tx({t, pins.strap, 1'h0}, 1'h0);
    tx(w[15:8], 1'h0);
    tx(w[7:0], 1'h0);
  endtask : adr
  task automatic wr(input logic [3:0] t, input logic [15:0] w,
                    input logic [7:0] b, input int n, input logic nack);
    adr(t, w);
    for (int i = 0; i < n; i++) tx(b + 8'(i), nack);
    m.stop();
    repeat (4) @(negedge clk);
    check("busy", {8'h00, busy}, {8'h00, !nack});
    m.start();
    tx({4'hA, pins.strap, 1'h0}, !nack);
    m.stop();
    wait_idle();
  endtask : wr
  task automatic rd(input logic [3:0] t, input logic [15:0] w,
                    input logic [7:0] b, input int n);
    adr(t, w);
    m.start();
    tx({t, pins.strap, 1'h1}, 1'h0);
    for (int i = 0; i < n; i++) rx(b + 8'(i), i == n - 1);
    m.stop();
  endtask : rd
  always @(posedge clk) begin
    if (res_v === 1'h1) begin
      check("bus byte", res_d,
            exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
    end
  end
  initial begin
    repeat (60000) @(negedge clk);
    check("run end", 9'h000, 9'h001);
    tally_and_finish();
  end
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    pins = '0;
    fails = 0;
    checked = 0;
    void'($urandom(33));
    pins.strap = 3'($urandom);
    a = {9'($urandom), 6'h15};
    d = 8'($urandom);
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    repeat (6) @(negedge clk);
    wr(4'hA, {1'h0, a}, d, 1, 1'h0);
    rd(4'hA, {1'h0, a}, d, 1);
    wr(4'hA, {1'h0, a[14:6], 6'h3F}, d + 8'h01, 2, 1'h0);
    rd(4'hA, {1'h0, a[14:6], 6'h00}, d + 8'h02, 1);
    pins.wp = 1'h1;
    wr(4'hA, {1'h0, a}, ~d, 1, 1'h1);
    pins.wp = 1'h0;
    rd(4'hA, {1'h0, a}, d, 1);
    for (int s = 0; s < 8; s++) begin
      pins.strap = 3'(s);
      m.start();
      tx({4'hA, 3'(s), 1'h0}, 1'h0);
      m.start();
      tx({4'hA, 3'(s + 1), 1'h0}, 1'h1);
      m.start();
      tx({4'h9, 3'(s), 1'h0}, 1'h1);
      m.stop();
    end
    wr(4'hB, 16'h0005, d, 1, 1'h0);
    rd(4'hB, 16'h0005, d, 1);
    wr(4'hB, 16'h0400, 8'h00, 1, 1'h0);
    wr(4'hB, 16'h0005, ~d, 1, 1'h1);
    rd(4'hB, 16'h0005, d, 1);
    rd(4'hB, 16'h0802, 8'h52, 3);
    repeat (20) @(negedge clk);
    tally_and_finish();
  end
endmodule : eep_target_tb_top
